// File: rtl/mss_pkg.sv
// Shared constants, helper functions and carrier types of the stream scheduler.
// Assumes a single 50 MHz core clock; rates are given in hertz or samples per second.
package mss_pkg;

    // Timing: the clock period in its own unit and the clock rate derived from it
    localparam int unsigned CLK_PERIOD_NS   = 20;
    localparam int unsigned CLK_HZ          = 1_000_000_000 / CLK_PERIOD_NS;

    // Default stream shape: about three clocks per sample and five channels
    localparam int unsigned SAMPLE_HZ_DEF   = 16_666_666;
    localparam int unsigned CHAN_TOTAL_DEF  = 5;
    localparam int unsigned DATA_W_DEF      = 16;
    localparam int unsigned FIFO_DEPTH_DEF  = 16;

    // The channel counter is always eight bits wide
    localparam int unsigned CHAN_W          = 8;
    localparam logic [7:0]  CHAN_RST        = 8'h00;

    // Folding factor: slots available per frame, at least one
    function automatic int unsigned fold_ratio(int unsigned clk_hz, int unsigned smp_hz);
        int unsigned r;
        r = clk_hz / smp_hz;
        return (r < 1) ? 1 : r;
    endfunction

    function automatic int unsigned ceil_div(int unsigned a, int unsigned b);
        return (a + b - 1) / b;
    endfunction

    // Control word that travels beside the lanes
    typedef struct packed {
        logic       valid;
        logic [7:0] channel;
    } mss_side_t;

    // Frame emitter state
    typedef enum logic [1:0] {
        MSS_ST_IDLE = 2'b00,
        MSS_ST_SEND = 2'b01
    } mss_state_t;

endpackage

// File: rtl/mss_scheduler.sv
// Multichannel stream scheduler: buffers per-channel sample groups and packs them
// onto parallel lanes with one shared valid flag and one shared channel counter.
// Assumes upstream writes sample groups in ascending channel order, one frame after
// another, and that the downstream stage expects the same lane and slot counts.
//
// Functional notes
// [R01] Equal rates: valid every clock, one-cycle frame
// [R02] Channel counter restarts at every frame start
// [R03] Slow single channel: valid low between samples
// [R04] Data and channel meaningless while valid low
// [R05] Channels in ascending consecutive slots, then idle
// [R06] Too many channels spread over parallel lanes
// [R07] Channels fill lanes in order, group by group
// [R08] One counter gives slot, not channel identity
// [R09] One valid covers all lanes; receiver discards empties
// [R10] Super-sample: several same-channel samples per clock
// [R11] Fold ratio is floor of rates, minimum one
// [R12] Lanes per channel is ceiling of rates
// [R13] Lane groups is ceiling of channels over fold
// [R14] Lane total is lanes per channel times groups
// [R15] Slots used per lane; counter runs below it
// [R16] Channels numbered zero to total minus one
// [R17] One parallel unit per vector element
// [R18] Narrower outputs multiplexed without external glue
// [R19] Merged streams regenerate valid and channel
// [R20] Consumer may select channels by counter decode
// [R21] Multichannel delays stretched by the channel total
// [R22] Eight-bit channel carried with the data
// [R23] Sender sends whole frames, pauses between them
// [R24] Both ends agree on lane and slot counts
// [R25] Unused slots invalid; counter wraps next frame
// [R26] Reset holds valid low, counter at zero
`timescale 1ns/10ps
`default_nettype none

module mss_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             core_clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    input  wire logic             wr_valid,
    output logic                  wr_ready,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  rd_valid,
    input  wire logic             rd_ready,
    output logic      [WIDTH-1:0] rd_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_q;
    logic             push;
    logic             pop;

    assign wr_ready = (count_q != CW'(DEPTH));
    assign rd_valid = (count_q != '0);
    assign rd_data  = mem_q[rd_ptr_q];
    assign push     = ce && wr_valid && wr_ready;
    assign pop      = ce && rd_valid && rd_ready;

    // Storage has no reset; only the pointers and the count define what is held
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    property p_no_overflow;
        @(posedge core_clk) disable iff (!nrst)
        count_q == CW'(DEPTH) && !pop |=> count_q == CW'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow)
        else $error("fifo count moved past depth");

    property p_no_underflow;
        @(posedge core_clk) disable iff (!nrst)
        count_q == '0 && !push |=> count_q == '0;
    endproperty
    a_no_underflow: assert property (p_no_underflow)
        else $error("fifo count moved below empty");
endmodule // mss_fifo

module mss_scheduler #(
    parameter int unsigned DATA_W     = mss_pkg::DATA_W_DEF,
    parameter int unsigned CHAN_TOTAL = mss_pkg::CHAN_TOTAL_DEF,
    parameter int unsigned CLK_HZ     = mss_pkg::CLK_HZ,
    parameter int unsigned SAMPLE_HZ  = mss_pkg::SAMPLE_HZ_DEF,
    parameter int unsigned FIFO_DEPTH = mss_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    input  wire logic                    in_valid,
    output logic                         in_ready,
    // Widths spelled out from the parameters, as the derived shape is declared below
    input  wire logic [mss_pkg::ceil_div(SAMPLE_HZ, CLK_HZ)*DATA_W-1:0] in_data,
    output mss_pkg::mss_side_t           out_side,
    output logic [mss_pkg::ceil_div(SAMPLE_HZ, CLK_HZ)
                  * mss_pkg::ceil_div(CHAN_TOTAL, mss_pkg::fold_ratio(CLK_HZ, SAMPLE_HZ))
                  * DATA_W-1:0]          out_lanes,
    output logic [7:0]                   lane_total,
    output logic [7:0]                   slots_used_per_lane
);
    // Stream shape derived once from the rates
    localparam int unsigned FOLD       = mss_pkg::fold_ratio(CLK_HZ, SAMPLE_HZ);     // R11
    localparam int unsigned LPC        = mss_pkg::ceil_div(SAMPLE_HZ, CLK_HZ);       // R12
    localparam int unsigned GROUPS     = mss_pkg::ceil_div(CHAN_TOTAL, FOLD);        // R13
    localparam int unsigned LANE_TOTAL = LPC * GROUPS;                               // R14
    localparam int unsigned SLOTS      = mss_pkg::ceil_div(CHAN_TOTAL, GROUPS);      // R15
    localparam int unsigned GRP_W      = LPC * DATA_W;
    localparam int unsigned SLOT_W     = (FOLD > 1) ? $clog2(FOLD) : 1;
    localparam int unsigned LOAD_W     = $clog2(CHAN_TOTAL + 1);
    localparam int unsigned CW         = mss_pkg::CHAN_W;

    logic [GRP_W-1:0]        fifo_data;
    logic                    fifo_valid;
    logic                    fifo_ready;
    logic                    pop;
    logic                    last_slot;
    logic                    take;
    logic [GRP_W-1:0]        load_mem_q [CHAN_TOTAL];
    logic [GRP_W-1:0]        emit_mem_q [CHAN_TOTAL];
    logic [LOAD_W-1:0]       load_cnt_q;
    logic [SLOT_W-1:0]       slot_q;
    mss_pkg::mss_state_t     state_q;
    mss_pkg::mss_side_t      side_d;
    logic [LANE_TOTAL*DATA_W-1:0] lanes_d;

    // The FIFO absorbs bursts; a full frame buffer stalls it and thus the source
    mss_fifo #(
        .WIDTH (GRP_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .nrst     (nrst),
        .ce       (ce),
        .wr_valid (in_valid),
        .wr_ready (in_ready),
        .wr_data  (in_data),
        .rd_valid (fifo_valid),
        .rd_ready (fifo_ready),
        .rd_data  (fifo_data)
    );

    assign lane_total          = 8'(LANE_TOTAL);                                     // R24
    assign slots_used_per_lane = 8'(SLOTS);                                          // R24
    assign last_slot           = (slot_q == SLOT_W'(FOLD - 1));
    // A frame is released only when every channel is held, so lanes never mix frames
    assign take       = ce && last_slot && (load_cnt_q == LOAD_W'(CHAN_TOTAL));      // R23
    assign fifo_ready = (load_cnt_q != LOAD_W'(CHAN_TOTAL)) || take;
    assign pop        = ce && fifo_valid && fifo_ready;

    // Loader: channel groups land at their own index, channel 0 first
    always_ff @(posedge core_clk) begin
        if (pop) begin
            load_mem_q[take ? '0 : load_cnt_q] <= fifo_data;                         // R16
        end
        if (take) begin
            emit_mem_q <= load_mem_q;                                                // R21
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            load_cnt_q <= '0;
        end else if (take) begin
            load_cnt_q <= pop ? LOAD_W'(1) : '0;
        end else if (pop) begin
            load_cnt_q <= load_cnt_q + 1'b1;
        end
    end

    // Frame timer: free-running slot count over the folding factor
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            slot_q <= '0;
        end else if (ce) begin
            slot_q <= last_slot ? '0 : slot_q + 1'b1;                                // R11
        end
    end

    // Emitter sends a frame only if one was taken at the previous frame boundary
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= mss_pkg::MSS_ST_IDLE;
        end else if (ce && last_slot) begin
            case (state_q)
                mss_pkg::MSS_ST_IDLE: state_q <= take ? mss_pkg::MSS_ST_SEND
                                                      : mss_pkg::MSS_ST_IDLE;
                mss_pkg::MSS_ST_SEND: state_q <= take ? mss_pkg::MSS_ST_SEND
                                                      : mss_pkg::MSS_ST_IDLE;
                default:              state_q <= mss_pkg::MSS_ST_IDLE;
            endcase
        end
    end

    // Shared valid and slot counter; unused slots carry zero and stay invalid
    always_comb begin
        side_d         = '0;
        side_d.valid   = (state_q == mss_pkg::MSS_ST_SEND) && (int'(slot_q) < SLOTS);  // R25
        side_d.channel = side_d.valid ? CW'(slot_q) : mss_pkg::CHAN_RST;                 // R08
    end

    // One selector per lane: group g, sub-lane k shows channel g*SLOTS+slot
    for (genvar g = 0; g < GROUPS; g++) begin : g_group
        for (genvar k = 0; k < LPC; k++) begin : g_sub
            always_comb begin
                int unsigned ch;
                ch = g * SLOTS + int'(slot_q);                                       // R07
                lanes_d[(g*LPC+k)*DATA_W +: DATA_W] = '0;                            // R04
                if (ch < CHAN_TOTAL) begin                                           // R09
                    lanes_d[(g*LPC+k)*DATA_W +: DATA_W] =
                        emit_mem_q[ch][k*DATA_W +: DATA_W];                          // R10
                end
            end
        end
    end
    // Each lane is its own parallel unit and lane muxing stays inside the block  // R17
    // so a narrower output needs no outer glue                                   // R18

    // Registered outputs; valid and channel are rebuilt here from the counter   // R19
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_side <= '0;                                                          // R26
        end else if (ce) begin
            out_side <= side_d;                                                      // R22
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            out_lanes <= '0;
        end else if (ce) begin
            out_lanes <= lanes_d;                                                    // R06
        end
    end

    // Checks, sampled only on enabled cycles
    // Frozen cycles are skipped as ticks, so no check sees a stale register
    default clocking cb @(posedge core_clk iff ce); endclocking
    default disable iff (!nrst);

    property p_frame_start_zero;
        (state_q == mss_pkg::MSS_ST_SEND) && (slot_q == '0)
            |=> out_side.valid && (out_side.channel == 8'h00);
    endproperty
    a_frame_start_zero: assert property (p_frame_start_zero) // R02
        else $error("frame did not start at channel zero");

    property p_counter_steps;
        out_side.valid && (out_side.channel < 8'(SLOTS - 1)) && ce
            |=> out_side.valid && (out_side.channel == $past(out_side.channel) + 8'h01);
    endproperty
    a_counter_steps: assert property (p_counter_steps) // R05
        else $error("channel counter skipped within frame");

    property p_counter_bound;
        out_side.valid |-> out_side.channel < 8'(SLOTS);
    endproperty
    a_counter_bound: assert property (p_counter_bound) // R15
        else $error("channel counter beyond slots used");

    property p_unused_invalid;
        (int'(slot_q) >= SLOTS) |=> !out_side.valid;
    endproperty
    a_unused_invalid: assert property (p_unused_invalid) // R25
        else $error("valid high in unused slot");

    property p_idle_invalid;
        (state_q == mss_pkg::MSS_ST_IDLE) |=> !out_side.valid;
    endproperty
    a_idle_invalid: assert property (p_idle_invalid) // R03
        else $error("valid high without a frame");

    property p_frame_period;
        last_slot |=> slot_q == '0 ##1 (FOLD == 1 || slot_q == SLOT_W'(1));
    endproperty
    a_frame_period: assert property (p_frame_period) // R01
        else $error("frame length differs from fold ratio");

    property p_lane0_data;
        take ##1 ce |=> out_lanes[DATA_W-1:0] == $past(load_mem_q[0][DATA_W-1:0], 2);
    endproperty
    a_lane0_data: assert property (p_lane0_data) // R07
        else $error("lane zero did not carry channel zero");

    property p_take_reload;
        take |=> load_cnt_q <= LOAD_W'(1);
    endproperty
    a_take_reload: assert property (p_take_reload) // R23
        else $error("frame buffer not emptied on release");

    property p_reset_quiet;
        disable iff (1'b0) !nrst |-> !out_side.valid && (out_side.channel == 8'h00);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) // R26
        else $error("outputs active during reset");

    property p_invalid_channel_zero;
        !out_side.valid |-> out_side.channel == mss_pkg::CHAN_RST;
    endproperty
    a_invalid_channel_zero: assert property (p_invalid_channel_zero) // R04
        else $error("channel counter not parked while invalid");

    property p_valid_needs_frame;
        out_side.valid |-> $past(state_q) == mss_pkg::MSS_ST_SEND;
    endproperty
    a_valid_needs_frame: assert property (p_valid_needs_frame) // R03
        else $error("valid high outside a released frame");

    property p_slot_range;
        int'(slot_q) < FOLD;
    endproperty
    a_slot_range: assert property (p_slot_range) // R11
        else $error("slot timer past the fold ratio");

    property p_load_bound;
        load_cnt_q <= LOAD_W'(CHAN_TOTAL);
    endproperty
    a_load_bound: assert property (p_load_bound) // R16
        else $error("more groups loaded than channels");

    property p_group0_full;
        take ##1 1'b1 |=> out_lanes[GRP_W-1:0] == $past(load_mem_q[0], 2);
    endproperty
    a_group0_full: assert property (p_group0_full) // R10
        else $error("first lane group lost a sub-sample");

    // Only checked inside a frame, as the buffer holds nothing before the first one
    property p_emit_hold;
        (state_q == mss_pkg::MSS_ST_SEND) && !take |=> $stable(emit_mem_q[0]);
    endproperty
    a_emit_hold: assert property (p_emit_hold) // R21
        else $error("frame buffer changed inside a frame");

    if (GROUPS > 1) begin : g_spread_chk
        property p_second_group;
            @(posedge core_clk iff ce) disable iff (!nrst)
            take ##1 1'b1 |=> out_lanes[GRP_W +: DATA_W]
                == $past(load_mem_q[SLOTS][DATA_W-1:0], 2);
        endproperty
        a_second_group: assert property (p_second_group) // R06
            else $error("second lane group did not open at the next channel");
    end

    c_frame_sent:  cover property (take ##FOLD out_side.valid);
    c_frame_skipped: cover property (last_slot && !take && load_cnt_q != '0);
    c_spread_tail: cover property (out_side.valid && out_side.channel == 8'(SLOTS - 1));
    c_fifo_full:   cover property (!in_ready);
    c_back_to_back: cover property (take ##FOLD take);
endmodule // mss_scheduler

`default_nettype wire

// File: verif/mss_sink.sv
// Downstream partner: decodes valid and slot counter, rebuilds whole frames.
// Assumes the shared clock enable, and lane and slot counts matching the source.
`timescale 1ns/10ps
`default_nettype none

module mss_sink #(
    parameter int unsigned DW    = 16,
    parameter int unsigned CH    = 5,
    parameter int unsigned LPC   = 1,
    parameter int unsigned SLOTS = 3,
    parameter int unsigned LANES = 2
) (
    input  wire logic                 core_clk,
    input  wire logic                 nrst,
    input  wire logic                 ce,
    input  wire mss_pkg::mss_side_t   side,
    input  wire logic [LANES*DW-1:0]  lanes,
    output logic                      frame_ok,
    output logic      [CH*LPC*DW-1:0] frame,
    output logic                      proto_err
);
    logic [7:0] prev_q;
    logic       prev_v_q;
    int         c;

    // Frozen outputs while ce is low are taken once, at the next enabled edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            frame_ok  <= 1'b0;
            proto_err <= 1'b0;
            prev_v_q  <= 1'b0;
            prev_q    <= 8'h00;
            frame     <= '0;
        end else begin
            frame_ok  <= 1'b0;
            proto_err <= 1'b0;
            if (ce) begin
                prev_v_q <= side.valid;
                prev_q   <= side.channel;
                if (side.valid) begin
                    if (side.channel >= SLOTS) proto_err <= 1'b1;
                    if (side.channel != 8'h00 && !(prev_v_q && prev_q + 8'h01 == side.channel))
                        proto_err <= 1'b1;
                    for (int l = 0; l < int'(LANES); l++) begin
                        c = int'((l / LPC) * SLOTS) + int'(side.channel);
                        // Slots past the channel total are empty and dropped
                        if (c < int'(CH)) frame[(c*LPC + l%LPC)*DW +: DW] <= lanes[l*DW +: DW];
                    end
                    if (side.channel == SLOTS - 1) frame_ok <= 1'b1;
                end
            end
        end
    end
endmodule // mss_sink

`default_nettype wire

// File: verif/test_multichannel_stream_scheduler.sv
// Testbench: two scheduler shapes, random data and clock enable, frames compared.
// Assumes the rtl package, scheduler and sink model are compiled before it.
`timescale 1ns/10ps
`default_nettype none

module test_multichannel_stream_scheduler;
    localparam int unsigned DW  = 16;
    localparam int unsigned CH  = 5;
    localparam int unsigned CH2 = 3;
    logic               core_clk  = 1'b0;
    logic               nrst      = 1'b0;
    logic               ce        = 1'b1;
    logic               rnd_ce    = 1'b0;
    logic               in_valid  = 1'b0;
    logic               in_valid2 = 1'b0;
    logic [DW-1:0]      in_data   = 16'h0000;
    logic [2*DW-1:0]    in_data2  = 32'h0000_0000;
    logic               saw_full  = 1'b0;
    wire logic          in_ready, in_ready2, fr1, fr2, pe1, pe2;
    wire logic [7:0]    lt1, su1, lt2, su2;
    wire logic [2*DW-1:0]      lanes1;
    wire logic [6*DW-1:0]      lanes2;
    wire logic [CH*DW-1:0]     frame1;
    wire logic [CH2*2*DW-1:0]  frame2;
    mss_pkg::mss_side_t side1, side2;
    logic [127:0]       q1[$], q2[$], acc1, acc2;
    int                 fail_count = 0, checked = 0, idx1 = 0, idx2 = 0;
    int                 seed = 32'h4a894969;

    mss_scheduler u_dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data), .out_side(side1), .out_lanes(lanes1),
        .lane_total(lt1), .slots_used_per_lane(su1));
    // Super-sample shape: two lanes per channel, one slot per frame
    mss_scheduler #(.CHAN_TOTAL(CH2), .SAMPLE_HZ(100_000_000)) u_dut2 (.core_clk(core_clk),
        .nrst(nrst), .ce(ce), .in_valid(in_valid2), .in_ready(in_ready2), .in_data(in_data2),
        .out_side(side2), .out_lanes(lanes2), .lane_total(lt2), .slots_used_per_lane(su2));
    mss_sink #(.CH(CH)) u_sink1 (.core_clk(core_clk), .nrst(nrst), .ce(ce), .side(side1),
        .lanes(lanes1), .frame_ok(fr1), .frame(frame1), .proto_err(pe1));
    mss_sink #(.CH(CH2), .LPC(2), .SLOTS(1), .LANES(6)) u_sink2 (.core_clk(core_clk),
        .nrst(nrst), .ce(ce), .side(side2), .lanes(lanes2), .frame_ok(fr2), .frame(frame2),
        .proto_err(pe2));

    always #10 core_clk = ~core_clk;
    always @(posedge core_clk) ce <= rnd_ce ? (($random(seed) & 7) != 0) : 1'b1;

    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input bit bad, input string m);
        checked++;
        if (bad) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    always @(negedge core_clk) begin
        if (nrst && !in_ready) saw_full = 1'b1;
        if (nrst) chk(pe1 !== 1'b0 || pe2 !== 1'b0, "slot order");
        if (fr1) chk(q1.size() == 0 || q1.pop_front() !== {48'h0, frame1}, "main frame");
        if (fr2) chk(q2.size() == 0 || q2.pop_front() !== {32'h0, frame2}, "wide frame");
    end

    // Request held from just after one edge up to the edge that takes it
    task automatic send(input bit sel, input logic [2*DW-1:0] d);
        int n;
        logic ok;
        n = 0;
        ok = 1'b0;
        if (sel) begin
            in_valid2 <= 1'b1;
            in_data2 <= d;
        end else begin
            in_valid <= 1'b1;
            in_data <= d[DW-1:0];
        end
        while (!ok) begin
            @(negedge core_clk);
            ok = ce && (sel ? in_ready2 : in_ready);
            @(posedge core_clk);
            n++;
            if (n > 500) begin
                chk(1'b1, "input stuck");
                test_done();
            end
        end
        if (sel) begin
            acc2[idx2*2*DW +: 2*DW] = d;
            idx2 = (idx2 + 1) % CH2;
            if (idx2 == 0) q2.push_back(acc2);
        end else begin
            acc1[idx1*DW +: DW] = d[DW-1:0];
            idx1 = (idx1 + 1) % CH;
            if (idx1 == 0) q1.push_back(acc1);
        end
    endtask

    task automatic burst(input bit sel, input int n);
        for (int i = 0; i < n; i++) send(sel, $random(seed));
        if (sel) in_valid2 <= 1'b0;
        else in_valid <= 1'b0;
    endtask

    initial begin
        acc1 = '0;
        acc2 = '0;
        repeat (10) @(posedge core_clk);
        chk(side1 !== '0 || side2 !== '0, "reset outputs");
        nrst <= 1'b1;
        chk(lt1 !== 8'h02 || su1 !== 8'h03, "main shape");
        chk(lt2 !== 8'h06 || su2 !== 8'h01, "wide shape");
        @(posedge core_clk);
        // Long enough that the slower frame drain lets the buffer fill and stall the source
        burst(1'b0, 24 * CH);
        burst(1'b1, 2 * CH2);
        rnd_ce <= 1'b1;
        burst(1'b0, 4 * CH);
        burst(1'b1, 4 * CH2);
        for (int i = 0; i < 600 && (q1.size() + q2.size()) > 0; i++) @(posedge core_clk);
        @(negedge core_clk);
        chk(q1.size() + q2.size() != 0, "frames lost");
        chk(!saw_full || in_ready !== 1'b1, "buffer fill and drain");
        test_done();
    end
endmodule // test_multichannel_stream_scheduler

`default_nettype wire
